// ### verilog/wmc_pkg.sv
`default_nettype none
// ============================================================
// wake unit miscellaneous control: shared constants and types
package wmc_pkg;

  localparam int unsigned WMC_ADDR_W = 4;
  localparam int unsigned WMC_DATA_W = 8;

  // register offset within the wake unit
  localparam logic [3:0] WMC_OFS_MISC_CTRL = 4'h1;

  // field positions of wake_misc_control
  localparam int unsigned WMC_BIT_LOCK     = 7;
  localparam int unsigned WMC_BIT_BAT_OK   = 5;
  localparam int unsigned WMC_BIT_PRIOR    = 2;
  localparam int unsigned WMC_BIT_SCHEME_H = 1;
  localparam int unsigned WMC_BIT_SCHEME_L = 0;

  // reset values, each from its own power domain
  localparam logic       WMC_RST_LOCK   = 1'h0;
  localparam logic       WMC_RST_BAT_OK = 1'h0;
  localparam logic       WMC_RST_PRIOR  = 1'h0;
  localparam logic [1:0] WMC_RST_SCHEME = 2'h2;
  localparam logic [7:0] WMC_RD_IDLE    = 8'h00;

  // led_scheme_select encodings
  typedef enum logic [1:0] {
    WMC_SCHEME_ADVANCED = 2'h0,
    WMC_SCHEME_BASIC    = 2'h1,
    WMC_SCHEME_SPECIAL  = 2'h2,
    WMC_SCHEME_RSVD     = 2'h3
  } wmc_scheme_type;

  // pin inputs, index order of the synchroniser vector
  localparam int unsigned WMC_PIN_N        = 4;
  localparam int unsigned WMC_PIN_BAT_LOW  = 0;
  localparam int unsigned WMC_PIN_MAIN_OFF = 1;
  localparam int unsigned WMC_PIN_STBY_OFF = 2;
  localparam int unsigned WMC_PIN_S3       = 3;

  // register access request from the unit's address decoder
  typedef struct packed {
    logic                  wr;
    logic                  rd;
    logic [WMC_ADDR_W-1:0] addr;
    logic [WMC_DATA_W-1:0] wdata;
  } wmc_req_type;

  // decode selects handed to the neighbouring led registers
  typedef struct packed {
    logic basic;
    logic advanced;
    logic special;
  } wmc_led_sel_type;

endpackage
`default_nettype wire

// ### verilog/wmc_misc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module wmc_misc_ctrl
  import wmc_pkg::*;
(
  input  wire logic            clk_i,
  input  wire logic            nrst_i,
  input  wire logic            nbat_rst_i,
  input  wire wmc_req_type     req_i,
  input  wire logic            battery_low_i,
  input  wire logic            main_supply_fail_i,
  input  wire logic            standby_supply_fail_i,
  input  wire logic            sleep_s3_indicator_i,
  output logic [7:0]           rd_data_o,
  output logic                 config_lock_o,
  output logic                 battery_ok_o,
  output logic                 prior_power_state_o,
  output wmc_led_sel_type      led_sel_o
);

  // ============================================================
  // pin synchronisers
  logic [WMC_PIN_N-1:0] pins_w;
  logic [WMC_PIN_N-1:0] sync_w;

  assign pins_w[WMC_PIN_BAT_LOW]  = battery_low_i;
  assign pins_w[WMC_PIN_MAIN_OFF] = main_supply_fail_i;
  assign pins_w[WMC_PIN_STBY_OFF] = standby_supply_fail_i;
  assign pins_w[WMC_PIN_S3]       = sleep_s3_indicator_i;

  // each pin owns its flop pair, so no vector has two writing processes
  genvar gi;
  generate
    for (gi = 0; gi < WMC_PIN_N; gi++) begin : g_sync
      logic meta_ff;
      logic stab_ff;

      always_ff @(posedge clk_i) begin
        if (!nbat_rst_i) begin
          meta_ff <= 1'b0;
          stab_ff <= 1'b0;
        end else begin
          meta_ff <= pins_w[gi];
          stab_ff <= meta_ff;
        end
      end

      assign sync_w[gi] = stab_ff;
    end
  endgenerate

  logic bat_low_w;
  logic fail_w;
  logic s3_w;
  logic fail_d_ff;
  logic fail_evt_w;

  assign bat_low_w  = sync_w[WMC_PIN_BAT_LOW];
  assign fail_w     = sync_w[WMC_PIN_MAIN_OFF] |
                      sync_w[WMC_PIN_STBY_OFF];
  assign s3_w       = sync_w[WMC_PIN_S3];
  // only the onset of a failure counts, so a long outage samples once
  assign fail_evt_w = fail_w & ~fail_d_ff;

  always_ff @(posedge clk_i) begin
    if (!nbat_rst_i) begin
      fail_d_ff <= 1'b0;
    end else begin
      fail_d_ff <= fail_w;
    end
  end

  // ============================================================
  // access decode
  function automatic logic hit_misc(input logic [WMC_ADDR_W-1:0] a);
    hit_misc = (a == WMC_OFS_MISC_CTRL);
  endfunction

  logic lock_ff;
  logic wr_hit_w;
  logic wr_ok_w;
  logic rd_hit_w;

  assign wr_hit_w = req_i.wr && hit_misc(req_i.addr);
  assign wr_ok_w  = wr_hit_w && !lock_ff;
  assign rd_hit_w = req_i.rd && hit_misc(req_i.addr);

  // ============================================================
  // configuration lock, standby domain
  logic nxt_lock;

  assign nxt_lock = lock_ff | (wr_ok_w & req_i.wdata[WMC_BIT_LOCK]);

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      lock_ff <= WMC_RST_LOCK;
    end else begin
      lock_ff <= nxt_lock;
    end
  end

  // ============================================================
  // battery-domain bits
  logic            bat_ok_ff;
  logic            prior_ff;
  wmc_scheme_type  scheme_ff;
  wmc_led_sel_type led_sel_ff;
  logic            nxt_bat_ok;
  logic            nxt_prior;
  wmc_scheme_type  nxt_scheme;
  wmc_led_sel_type nxt_led_sel;

  // one decode serves both the reset value and the running value
  function automatic wmc_led_sel_type scheme_sel(input wmc_scheme_type s);
    wmc_led_sel_type sel;
    sel          = '0;
    sel.basic    = (s == WMC_SCHEME_BASIC);
    sel.advanced = (s == WMC_SCHEME_ADVANCED);
    sel.special  = (s == WMC_SCHEME_SPECIAL);
    return sel;
  endfunction

  assign nxt_bat_ok = bat_low_w  ? 1'b0 :
                      fail_evt_w ? 1'b1 : bat_ok_ff;
  // high s3 level means forced shutdown
  assign nxt_prior  = fail_evt_w ? s3_w : prior_ff;
  assign nxt_scheme = wr_ok_w ?
      wmc_scheme_type'(req_i.wdata[WMC_BIT_SCHEME_H:WMC_BIT_SCHEME_L]) :
      scheme_ff;
  // selects from flops, decoded from the next code to stay in step
  assign nxt_led_sel = scheme_sel(nxt_scheme);

  always_ff @(posedge clk_i) begin
    if (!nbat_rst_i) begin
      bat_ok_ff  <= WMC_RST_BAT_OK;
      prior_ff   <= WMC_RST_PRIOR;
      scheme_ff  <= wmc_scheme_type'(WMC_RST_SCHEME);
      led_sel_ff <= scheme_sel(wmc_scheme_type'(WMC_RST_SCHEME));
    end else begin
      bat_ok_ff  <= nxt_bat_ok;
      prior_ff   <= nxt_prior;
      scheme_ff  <= nxt_scheme;
      led_sel_ff <= nxt_led_sel;
    end
  end

  // ============================================================
  // read-back and outputs
  logic [7:0] reg_view_w;
  logic [7:0] rd_data_ff;
  logic [7:0] nxt_rd_data;

  always_comb begin
    reg_view_w                 = 8'h00;
    reg_view_w[WMC_BIT_LOCK]   = lock_ff;
    reg_view_w[WMC_BIT_BAT_OK] = bat_ok_ff;
    reg_view_w[WMC_BIT_PRIOR]  = prior_ff;
    reg_view_w[WMC_BIT_SCHEME_H:WMC_BIT_SCHEME_L] = scheme_ff;
  end

  // unmapped offsets answer zero; their owners drive their own data
  assign nxt_rd_data = rd_hit_w ? reg_view_w : WMC_RD_IDLE;

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rd_data_ff <= WMC_RD_IDLE;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign rd_data_o           = rd_data_ff;
  assign config_lock_o       = lock_ff;
  // software qualifies prior state with this flag
  assign battery_ok_o        = bat_ok_ff;
  assign prior_power_state_o = prior_ff;
  // decode selects; reserved code selects nothing
  assign led_sel_o           = led_sel_ff;

  // ============================================================
  // assertions
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i || !nbat_rst_i);

  sequence s_lock_write;
    wr_hit_w && !lock_ff && req_i.wdata[WMC_BIT_LOCK];
  endsequence

  sequence s_misc_read;
    rd_hit_w ##1 1'b1;
  endsequence

  sequence s_supply_onset;
    !fail_w ##1 fail_w;
  endsequence

  sequence s_supply_held;
    fail_w ##1 fail_w;
  endsequence

  chk_lock_sets: assert property (
    s_lock_write |=> lock_ff)
    else $error("lock not set by write of one");

  chk_lock_sticky: assert property (
    lock_ff |=> lock_ff [*3])
    else $error("lock cleared without reset");

  chk_locked_frozen: assert property (
    (lock_ff && wr_hit_w) |=> $stable(scheme_ff))
    else $error("scheme written while locked");

  chk_lowbat_clears: assert property (
    bat_low_w |=> !battery_ok_o)
    else $error("battery flag set while battery low");

  chk_fail_sets_ok: assert property (
    (fail_evt_w && !bat_low_w) |=> battery_ok_o)
    else $error("battery flag not set on supply failure");

  chk_prior_capture: assert property (
    fail_evt_w |=> prior_power_state_o == $past(s3_w))
    else $error("prior state did not capture s3 level");

  chk_prior_hold: assert property (
    !fail_evt_w |=> $stable(prior_ff))
    else $error("prior state changed without failure");

  chk_prior_reset: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    !nbat_rst_i |=> !prior_power_state_o)
    else $error("prior state not cleared by battery reset");

  chk_scheme_decode: assert property (
    led_sel_o.special == (scheme_ff == WMC_SCHEME_SPECIAL) &&
    led_sel_o.basic == (scheme_ff == WMC_SCHEME_BASIC) &&
    led_sel_o.advanced == (scheme_ff == WMC_SCHEME_ADVANCED) &&
    $onehot0({led_sel_o.basic, led_sel_o.advanced, led_sel_o.special}))
    else $error("led decode select wrong");

  chk_read_value: assert property (
    s_misc_read |-> rd_data_o == $past(reg_view_w) &&
    rd_data_o[6] == 1'b0 && rd_data_o[4:3] == 2'b00)
    else $error("read data wrong or reserved bits set");

  chk_scheme_write: assert property (
    wr_ok_w |=> scheme_ff == $past(req_i.wdata[1:0]))
    else $error("scheme write lost while unlocked");

  chk_lock_zero_write: assert property (
    (wr_hit_w && !lock_ff && !req_i.wdata[WMC_BIT_LOCK]) |=> !lock_ff)
    else $error("lock set by write of zero");

  chk_lock_reset: assert property (
    @(posedge clk_i) disable iff (1'b0)
    !nrst_i |=> !config_lock_o)
    else $error("lock not cleared by reset");

  chk_onset_sets_ok: assert property (
    (s_supply_onset ##0 !bat_low_w) |=> battery_ok_o)
    else $error("battery flag not set at failure onset");

  chk_onset_capture: assert property (
    s_supply_onset |=> prior_power_state_o == $past(s3_w))
    else $error("prior state missed s3 level at failure onset");

  chk_held_fail_quiet: assert property (
    s_supply_held |=> $stable(prior_power_state_o))
    else $error("prior state resampled during a held failure");

  chk_prior_write_ignored: assert property (
    (wr_hit_w && !fail_evt_w) |=> $stable(prior_power_state_o))
    else $error("write changed prior state");

  chk_battery_reset: assert property (
    @(posedge clk_i) disable iff (1'b0)
    !nbat_rst_i |=> !battery_ok_o && scheme_ff == WMC_SCHEME_SPECIAL &&
    led_sel_o.special && !led_sel_o.basic && !led_sel_o.advanced)
    else $error("battery-domain bits not at reset value");

  chk_reserved_zero: assert property (
    rd_data_o[6] == 1'b0 && rd_data_o[4:3] == 2'b00)
    else $error("reserved read bits not zero");

endmodule
`default_nettype wire

// ### testbench/wmc_misc_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module wmc_misc_ctrl_test
  import wmc_pkg::*;
;
  logic            clk_i      = 1'b0;
  logic            nrst_i     = 1'b0;
  logic            nbat_rst_i = 1'b0;
  wmc_req_type     req_i      = '0;
  logic [3:0]      pin_v      = 4'h0;
  logic [7:0]      rd_data_o;
  logic            lock_o;
  logic            bat_o;
  logic            prior_o;
  wmc_led_sel_type sel_o;
  logic [7:0]      wd;
  int              mismatches = 0;
  int              checks     = 0;
  int              m_lock;
  int              m_bat;
  int              m_prior;
  int              m_sch;
  int              rdq[$];

  always #2.5 clk_i = ~clk_i;

  // pin_v packs {battery_low, main_fail, standby_fail, sleep_s3}
  wmc_misc_ctrl uut (
    .clk_i                 (clk_i),
    .nrst_i                (nrst_i),
    .nbat_rst_i            (nbat_rst_i),
    .req_i                 (req_i),
    .battery_low_i         (pin_v[3]),
    .main_supply_fail_i    (pin_v[2]),
    .standby_supply_fail_i (pin_v[1]),
    .sleep_s3_indicator_i  (pin_v[0]),
    .rd_data_o             (rd_data_o),
    .config_lock_o         (lock_o),
    .battery_ok_o          (bat_o),
    .prior_power_state_o   (prior_o),
    .led_sel_o             (sel_o)
  );

  // ==========================================================
  // compare and report
  task automatic cmp8(string nm, logic [7:0] exp, logic [7:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic cmp1(string nm, logic exp, logic got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s exp %b got %b", nm, exp, got);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================================
  // model and drivers
  function automatic logic [7:0] mval();
    return {m_lock[0], 1'b0, m_bat[0], 2'h0, m_prior[0], m_sch[1:0]};
  endfunction

  task automatic chk_out();
    cmp1("config_lock_o", m_lock[0], lock_o);
    cmp1("battery_ok_o", m_bat[0], bat_o);
    cmp1("prior_power_state_o", m_prior[0], prior_o);
    cmp8("led_sel_o", {5'h00, m_sch == 1, m_sch == 0, m_sch == 2},
         {5'h00, sel_o});
  endtask

  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(negedge clk_i);
    req_i = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk_i);
    req_i = '0;
    if (a == WMC_OFS_MISC_CTRL && m_lock == 0) begin
      m_lock = d[7];
      m_sch = d[1:0];
    end
  endtask

  task automatic rd(logic [3:0] a);
    @(negedge clk_i);
    req_i = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    rdq.push_back((a == WMC_OFS_MISC_CTRL) ? int'(mval()) : 0);
    @(negedge clk_i);
    req_i = '0;
    cmp8("rd_data_o", 8'(rdq.pop_front()), rd_data_o);
    if (a == WMC_OFS_MISC_CTRL && m_bat != 0) begin
      cmp1("prior_valid", m_prior[0], rd_data_o[WMC_BIT_PRIOR]);
    end
  endtask

  // only the onset of a failure resamples, and low battery wins
  task automatic pins(logic [3:0] v);
    logic onset;
    onset = (v[2] | v[1]) & ~(pin_v[2] | pin_v[1]);
    @(negedge clk_i);
    pin_v = v;
    if (onset) m_prior = v[0];
    if (v[3]) m_bat = 0;
    else if (onset) m_bat = 1;
    repeat (4) @(negedge clk_i);
    chk_out();
  endtask

  task automatic rst(logic std, logic bat);
    @(negedge clk_i);
    nrst_i = ~std;
    nbat_rst_i = ~bat;
    repeat (2) @(negedge clk_i);
    nrst_i = 1'b1;
    nbat_rst_i = 1'b1;
    if (std) m_lock = 0;
    if (bat) begin
      m_bat = 0;
      m_prior = 0;
      m_sch = 2;
    end
  endtask

  // ==========================================================
  // main sequence
  initial begin
    m_lock = 0;
    m_bat = 0;
    m_prior = 0;
    m_sch = 2;
    wd = 8'($urandom(32'h6c0a));
    repeat (4) @(negedge clk_i);
    nrst_i = 1'b1;
    nbat_rst_i = 1'b1;
    chk_out();
    rd(WMC_OFS_MISC_CTRL);
    for (int c = 0; c < 4; c++) begin
      wd = 8'($urandom);
      wr(WMC_OFS_MISC_CTRL, {1'b0, wd[6:2], c[1:0]});
      chk_out();
      rd(WMC_OFS_MISC_CTRL);
    end
    rd(4'h3);
    wr(4'h5, 8'h81);
    chk_out();
    pins(4'h5);
    rd(WMC_OFS_MISC_CTRL);
    pins(4'h0);
    pins(4'h2);
    pins(4'ha);
    pins(4'h9);
    pins(4'hd);
    pins(4'h0);
    wr(WMC_OFS_MISC_CTRL, 8'h81);
    chk_out();
    wr(WMC_OFS_MISC_CTRL, 8'h7e);
    chk_out();
    rd(WMC_OFS_MISC_CTRL);
    rst(1'b1, 1'b0);
    chk_out();
    wr(WMC_OFS_MISC_CTRL, 8'h83);
    chk_out();
    rst(1'b0, 1'b1);
    chk_out();
    rd(WMC_OFS_MISC_CTRL);
    results();
  end

  // hang guard: the whole run needs far fewer cycles than this
  initial begin
    #100us;
    mismatches++;
    results();
  end
endmodule
`default_nettype wire
